// ---- rtl/ssi_top.sv ----
// starter status indicator: fault code latching, lamp drive, view toggle, wishbone slave
// assumes synchronous inputs from protection, sequencer and panel key logic on one clock
// Functional notes
// - overcurrent trip shows one of two overcurrent codes
// - missing input phase shows the phase-loss code
// - overheat shows its code; clears itself once temperature is safe
// - overload or jam trip shows the overload code
// - bypass within one second of start raises premature-bypass code
// - start finishing with no load also raises premature-bypass code
// - running lamp lit after start completes in state view under keypad control, dark in standby
// - delay lamp lit from delay start until delay end under keypad control
// - external-control lamp lit while terminals control except in current view, dark for keypad
// - first mode key press in start lights current lamp, shows current
// - next press clears current lamp, shows state again; presses toggle
// - each lamp is lit or dark; only the state's own lamp lit
`timescale 1ns/1ps
`include "ssi_params.svh"

module ssi_top
  import ssi_pkg::*;
#(
  parameter int unsigned BYPASS_MIN_CYCLES = `SSI_BYPASS_MIN_MS * 1000 * `SSI_CLK_MHZ,
  parameter int unsigned CNT_W = 28
) (
  input wire logic clk,
  input wire logic reset,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // protection and sequencer
  input wire ssi_prot_t prot,
  input wire logic start_delay_begin,
  input wire logic start_delay_end,
  input wire logic start_begin,
  input wire logic bypass_closed,
  input wire logic start_done,
  input wire logic no_load,
  input wire logic stop_cmd,
  input wire logic external_control,
  input wire logic mode_key,
  // panel
  output logic [3:0] display_code,
  output ssi_lamps_t lamps,
  output logic irq
);

  // the start timer must hold the whole guard window without wrapping
  initial begin
    if (CNT_W < 2 || BYPASS_MIN_CYCLES < 1 || BYPASS_MIN_CYCLES >= (64'd1 << CNT_W)) begin
      $error("ssi_top: bypass count does not fit counter");
    end
    // the guard parameter is 32 bits, so a wider counter would only waste flops
    if (CNT_W > 32) begin
      $error("ssi_top: counter wider than the guard parameter");
    end
  end

  // byte-lane merge shared by the ctrl and irq mask registers
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // one register hit test for every write strobe, so offsets are compared in one place
  // and a new register cannot be decoded differently by two processes
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    return adr == off;
  endfunction

  ssi_phase_t phase;
  ssi_phase_t next_phase;
  logic [CNT_W-1:0] start_cnt;
  logic [31:0] ctrl;
  logic [`SSI_IRQ_W-1:0] irq_stat;
  logic [`SSI_IRQ_W-1:0] irq_mask;
  logic [3:0] fault_code;
  logic [3:0] last_fault;
  logic current_view;
  logic mode_key_q;
  logic key_press;
  logic bypass_q;
  logic bypass_rise;
  logic early_bypass;
  logic no_load_done;
  logic [`SSI_IRQ_W-1:0] events;
  logic [3:0] next_fault;
  logic fault_active;
  logic fault_ack;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] next_rdata;
  logic wr_ctrl;
  logic wr_mask;
  logic wr_stat;
  logic [4:0] stat_clr;
  logic [31:0] ctrl_merged;
  logic [31:0] mask_merged;
  logic [31:0] status_word;
  ssi_lamps_t next_lamps;
  logic [3:0] next_display;

  // wishbone decode; ack one cycle after request, dropped the cycle after
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign bus_rd = bus_req & ~wb_we_i;
  assign wr_ctrl = bus_wr & reg_hit(wb_adr_i, `SSI_REG_CTRL);
  assign wr_mask = bus_wr & reg_hit(wb_adr_i, `SSI_REG_IRQ_MASK);
  assign wr_stat = bus_wr & reg_hit(wb_adr_i, `SSI_REG_IRQ_STAT);
  // acknowledge through byte lane 0 only, matching the ctrl field layout
  assign fault_ack = wr_ctrl & wb_sel_i[0] & wb_dat_i[`SSI_CTRL_ACK_BIT];

  // lane merges; the ack bit is never stored, so a later write of other bits
  // cannot repeat an old acknowledge
  assign ctrl_merged = merge_lanes(ctrl, wb_dat_i, wb_sel_i) & 32'h0000_0002;
  assign mask_merged = merge_lanes({27'h000_0000, irq_mask}, wb_dat_i, wb_sel_i);
  // write-one-to-clear only through byte lane 0, as the status fits in it
  assign stat_clr = (wr_stat & wb_sel_i[0]) ? wb_dat_i[4:0] : 5'h00;
  // status word: [8] current view, [7:4] lamps, [3:1] phase, [0] control source
  assign status_word = {23'h00_0000, current_view, lamps, phase, external_control};

  // edge detection on key and bypass contact; both flops reset low, the idle level
  // of the key and of an open contact, so no false edge follows reset
  assign key_press = mode_key & ~mode_key_q;
  assign bypass_rise = bypass_closed & ~bypass_q;

  // premature bypass: guard enable bit lets software turn the check off;
  // only the closing edge is judged, so a contact held closed raises one event
  assign early_bypass = ctrl[`SSI_CTRL_BYPASS_GUARD_EN_BIT] && phase == SSI_STARTING && bypass_rise
                        && start_cnt < CNT_W'(BYPASS_MIN_CYCLES);
  assign no_load_done = ctrl[`SSI_CTRL_BYPASS_GUARD_EN_BIT] && phase == SSI_STARTING
                        && start_done && no_load;

  // fault events, one per interrupt bit; levels, so a live fault keeps re-setting its bit
  assign events[`SSI_IRQ_OC] = prot.overcurrent | prot.overcurrent_hi;
  assign events[`SSI_IRQ_PF] = prot.phase_loss;
  assign events[`SSI_IRQ_OH] = prot.overheat;
  assign events[`SSI_IRQ_OL] = prot.overload;
  assign events[`SSI_IRQ_PB] = early_bypass | no_load_done;

  // code selection: live faults in a fixed priority, overheat tracks its input
  // a fault that has gone stays shown until acknowledged, so a short trip is not missed
  always_comb begin
    next_fault = fault_code;
    if (prot.overcurrent_hi) begin
      next_fault = `SSI_CODE_OC2;
    end else if (prot.overcurrent) begin
      next_fault = `SSI_CODE_OC1;
    end else if (prot.phase_loss) begin
      next_fault = `SSI_CODE_PF;
    end else if (prot.overheat) begin
      next_fault = `SSI_CODE_OH;
    end else if (prot.overload) begin
      next_fault = `SSI_CODE_OL;
    end else if (events[`SSI_IRQ_PB]) begin
      next_fault = `SSI_CODE_PB;
    end else if (fault_code == `SSI_CODE_OH) begin
      next_fault = `SSI_CODE_NONE; // self-release when temperature safe
    end else if (fault_ack) begin
      next_fault = `SSI_CODE_NONE;
    end
  end

  assign fault_active = fault_code != `SSI_CODE_NONE;

  // operating phase sequence; a fault stops the start
  // stop and new faults override every transition so standby is always reachable
  always_comb begin
    next_phase = phase;
    case (phase)
      SSI_STANDBY: begin
        if (start_delay_begin) begin
          next_phase = SSI_DELAY;
        end else if (start_begin) begin
          next_phase = SSI_STARTING;
        end
      end
      SSI_DELAY: begin
        if (start_delay_end) begin
          next_phase = SSI_STARTING;
        end
      end
      SSI_STARTING: begin
        if (start_done && !no_load_done) begin
          next_phase = SSI_RUNNING;
        end
      end
      SSI_RUNNING: begin
        next_phase = SSI_RUNNING;
      end
      default: begin
        next_phase = SSI_STANDBY;
      end
    endcase
    if (stop_cmd || (next_fault != `SSI_CODE_NONE && next_fault != fault_code) || early_bypass) begin
      next_phase = SSI_STANDBY;
    end
  end

  // read mux; unmapped offsets read zero so software probing is harmless
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `SSI_REG_CTRL: next_rdata = ctrl;
      `SSI_REG_STATUS: next_rdata = status_word;
      `SSI_REG_IRQ_STAT: next_rdata = {27'h000_0000, irq_stat};
      `SSI_REG_IRQ_MASK: next_rdata = {27'h000_0000, irq_mask};
      `SSI_REG_FAULT: next_rdata = {24'h00_0000, last_fault, fault_code};
      default: next_rdata = 32'h0000_0000; // unmapped reads zero, still acked
    endcase
  end

  // bus slave registers; read data is held between reads to keep the bus quiet
  always_ff @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl <= `SSI_CTRL_RESET;
      irq_mask <= 5'h00;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_rd) begin
        wb_dat_o <= next_rdata;
      end
      if (wr_ctrl) begin
        ctrl <= ctrl_merged; // ack bit self-clears
      end
      if (wr_mask) begin
        irq_mask <= mask_merged[4:0];
      end
    end
  end

  // sticky status, one flop per source; the set term is ORed last so an event
  // arriving with its own clear stays visible and is never lost
  for (genvar b = 0; b < `SSI_IRQ_W; b++) begin : g_stat
    always_ff @(posedge clk) begin
      if (reset) begin
        irq_stat[b] <= 1'b0;
      end else begin
        irq_stat[b] <= (irq_stat[b] & ~stat_clr[b]) | events[b];
      end
    end
  end

  // level interrupt from a flop, one cycle behind the status bits; the lag buys a
  // glitch-free pin at the cost of one clock of latency
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // phase, start timer and fault latch
  // the timer restarts whenever the start phase is left, so each start is judged alone
  always_ff @(posedge clk) begin
    if (reset) begin
      phase <= SSI_STANDBY;
      start_cnt <= '0;
      fault_code <= `SSI_CODE_NONE;
      last_fault <= `SSI_CODE_NONE;
      mode_key_q <= 1'b0;
      bypass_q <= 1'b0;
    end else begin
      phase <= next_phase;
      mode_key_q <= mode_key;
      bypass_q <= bypass_closed;
      if (phase != SSI_STARTING) begin
        start_cnt <= '0;
      end else if (start_cnt != '1) begin
        start_cnt <= start_cnt + 1'b1; // saturates so a long ramp never wraps
      end
      fault_code <= next_fault;
      if (next_fault != fault_code && fault_code != `SSI_CODE_NONE) begin
        last_fault <= fault_code;
      end
    end
  end

  // view toggle: only key presses during the start sequence flip it
  // standby clears the view so a new start always opens on the state view
  always_ff @(posedge clk) begin
    if (reset) begin
      current_view <= 1'b0;
    end else if (phase == SSI_STANDBY) begin
      current_view <= 1'b0;
    end else if (key_press && phase == SSI_STARTING) begin
      current_view <= ~current_view;
    end
  end

  // lamp priority: current view over control source over phase lamps, which keeps
  // at most one lamp lit even when the inputs overlap
  always_comb begin
    next_lamps = '0;
    next_lamps.current_view_lamp = current_view;
    next_lamps.external_control_lamp = ~current_view & external_control;
    next_lamps.delay_lamp = ~current_view & ~external_control & (phase == SSI_DELAY);
    next_lamps.run_lamp = ~current_view & ~external_control & (phase == SSI_RUNNING);
  end

  // a latched fault outranks both views so the operator cannot miss it
  assign next_display = fault_active ? fault_code :
                        (current_view ? `SSI_CODE_CURRENT : `SSI_CODE_STATE);

  // panel outputs straight from flops
  always_ff @(posedge clk) begin
    if (reset) begin
      lamps <= '0;
      display_code <= `SSI_CODE_STATE;
    end else begin
      lamps <= next_lamps;
      display_code <= next_display;
    end
  end

endmodule

// ---- rtl/ssi_params.svh ----
// constants for the starter status indicator: register offsets, field bits, reset values, timing
// assumes a 32-bit classic wishbone slave on a 250 MHz clock
`ifndef SSI_PARAMS_SVH
`define SSI_PARAMS_SVH

// register byte offsets
`define SSI_REG_CTRL 8'h00
`define SSI_REG_STATUS 8'h04
`define SSI_REG_IRQ_STAT 8'h08
`define SSI_REG_IRQ_MASK 8'h0c
`define SSI_REG_FAULT 8'h10

// ctrl fields
`define SSI_CTRL_ACK_BIT 0
`define SSI_CTRL_BYPASS_GUARD_EN_BIT 1
`define SSI_CTRL_RESET 32'h0000_0002

// interrupt bits: one per fault source
`define SSI_IRQ_OC 0
`define SSI_IRQ_PF 1
`define SSI_IRQ_OH 2
`define SSI_IRQ_OL 3
`define SSI_IRQ_PB 4
`define SSI_IRQ_W 5

// panel display codes
`define SSI_CODE_NONE 4'h0
`define SSI_CODE_OH 4'h1
`define SSI_CODE_OC1 4'h2
`define SSI_CODE_PF 4'h3
`define SSI_CODE_OL 4'h4
`define SSI_CODE_PB 4'h5
`define SSI_CODE_OC2 4'h6
`define SSI_CODE_STATE 4'h8
`define SSI_CODE_CURRENT 4'h9

// least start-to-bypass time
`define SSI_BYPASS_MIN_MS 1000
`define SSI_CLK_MHZ 250

`endif

// ---- rtl/ssi_pkg.sv ----
// types for the starter status indicator
// assumes ssi_params.svh is included by the design file
package ssi_pkg;

  typedef enum logic [2:0] {
    SSI_STANDBY,
    SSI_DELAY,
    SSI_STARTING,
    SSI_RUNNING
  } ssi_phase_t;

  // raw protection inputs from the detection logic
  typedef struct packed {
    logic overcurrent;
    logic overcurrent_hi;
    logic phase_loss;
    logic overheat;
    logic overload;
  } ssi_prot_t;

  // lamp outputs, one bit per lamp
  typedef struct packed {
    logic run_lamp;
    logic delay_lamp;
    logic external_control_lamp;
    logic current_view_lamp;
  } ssi_lamps_t;

endpackage

// ---- verif/ssi_top_chk.sv ----
// checker: bus handshake, fault code priority and lamp relations of ssi_top
// assumes bound to ssi_top; one clock, synchronous active-high reset
`timescale 1ns/1ps
`include "ssi_params.svh"
module ssi_top_chk
  import ssi_pkg::*;
#(
  parameter int unsigned BYPASS_MIN_CYCLES = 100,
  parameter int unsigned CNT_W = 28
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire ssi_prot_t prot,
  input wire logic stop_cmd,
  input wire logic [3:0] display_code,
  input wire ssi_lamps_t lamps
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // codes that may outrank a live lower fault, by priority
  wire pf_up = display_code inside {`SSI_CODE_OC1, `SSI_CODE_OC2, `SSI_CODE_PF};
  wire oh_up = pf_up || display_code == `SSI_CODE_OH;
  wire ol_up = oh_up || display_code == `SSI_CODE_OL;
  // slave answers one cycle after take, for one cycle
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_latency_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  oc_code_a:
    assert property (prot.overcurrent_hi |-> ##2 display_code == `SSI_CODE_OC2) else $error("oc code missing");
  pf_code_a:
    assert property (prot.phase_loss |-> ##2 pf_up) else $error("phase loss code missing");
  oh_code_a:
    assert property (prot.overheat |-> ##2 oh_up) else $error("overheat code missing");
  ol_code_a:
    assert property (prot.overload |-> ##2 ol_up) else $error("overload code missing");
  lamp_onehot_a:
    assert property ($onehot0(lamps)) else $error("two lamps lit");
  stop_dark_a:
    assert property (stop_cmd |-> ##2 !lamps.run_lamp) else $error("run lamp lit in standby");
  cover property (display_code == `SSI_CODE_PB);
  cover property (lamps.current_view_lamp);
  cover property (lamps.run_lamp);
endmodule

// ---- verif/ssi_panel_op.sv ----
// operator model: presses the mode key when the bench asks
// assumes press is a one-cycle request on clk
`timescale 1ns/1ps
module ssi_panel_op (
  input wire logic clk,
  input wire logic press,
  output logic mode_key
);
  logic [1:0] hold = 2'h0;
  // key held four edges like a finger, then released low (contact opens)
  always @(posedge clk) begin
    if (press) begin
      hold <= 2'h3;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end
    mode_key <= press || hold != 2'h0;
  end
  initial mode_key = 1'b0;
endmodule

// ---- verif/starter_status_indicator_bench.sv ----
// bench for the starter status indicator: bus, fault codes, lamps, mode key
// assumes ssi_top, ssi_panel_op and ssi_top_chk compiled before it
`timescale 1ns/1ps
`include "ssi_params.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module starter_status_indicator_bench import ssi_pkg::*;;
  logic clk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, key;
  logic sb = 1'b0, byp = 1'b0, sd = 1'b0, nl = 1'b0, stp = 1'b0, ext = 1'b0, sdb = 1'b0, sde = 1'b0;
  logic press = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, dat_o, q;
  logic [3:0] code;
  ssi_prot_t prot = '0;
  ssi_lamps_t lamps;
  int mismatches = 0, checked = 0;
  logic [3:0] codes [5] = '{`SSI_CODE_OC1, `SSI_CODE_OC2, `SSI_CODE_PF, `SSI_CODE_OH, `SSI_CODE_OL};
  int bi [5] = '{0, 0, 1, 2, 3};
  // short guard time keeps the premature-bypass window at 100 cycles
  ssi_top #(.BYPASS_MIN_CYCLES(100), .CNT_W(28)) u_dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .prot(prot), .start_delay_begin(sdb), .start_delay_end(sde), .start_begin(sb),
    .bypass_closed(byp), .start_done(sd), .no_load(nl), .stop_cmd(stp), .external_control(ext),
    .mode_key(key), .display_code(code), .lamps(lamps), .irq(irq));
  ssi_panel_op u_op (.clk(clk), .press(press), .mode_key(key));
  // 4 ns clock
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic st(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one classic cycle; read data lands in q at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  // fault acknowledge keeps the bypass guard enabled, then clears status
  task automatic clr(input logic [31:0] m);
    wb(1'b1, `SSI_REG_CTRL, 32'h3);
    wb(1'b1, `SSI_REG_IRQ_STAT, m);
    st(3);
  endtask
  initial begin
    st(8);
    reset <= 1'b0;
    wb(1'b0, `SSI_REG_CTRL, 32'h0);
    `CHK(q, `SSI_CTRL_RESET)
    `CHK(code, `SSI_CODE_STATE)
    wb(1'b1, `SSI_REG_IRQ_MASK, 32'h1f);
    wb(1'b0, `SSI_REG_IRQ_MASK, 32'h0);
    `CHK(q, 32'h1f)
    wb(1'b0, 8'h20, 32'h0);
    `CHK(q, 32'h0)
    // every protection source, held then dropped before acknowledge
    for (int i = 0; i < 5; i++) begin
      prot <= ssi_prot_t'(5'h10 >> i);
      st(3);
      `CHK(code, codes[i])
      `CHK(irq, 1'b1)
      wb(1'b0, `SSI_REG_IRQ_STAT, 32'h0);
      `CHK(q, 32'h1 << bi[i])
      prot <= '0;
      st(3);
      `CHK(code, i == 3 ? `SSI_CODE_STATE : codes[i])
      clr(32'h1 << bi[i]);
      `CHK(code, `SSI_CODE_STATE)
      `CHK(irq, 1'b0)
    end
    wb(1'b0, `SSI_REG_FAULT, 32'h0);
    `CHK(q, {24'h00_0000, `SSI_CODE_OL, `SSI_CODE_NONE})
    // bypass 10 cycles into start
    sb <= 1'b1;
    st(1);
    sb <= 1'b0;
    st(10);
    byp <= 1'b1;
    st(3);
    `CHK(code, `SSI_CODE_PB)
    byp <= 1'b0;
    clr(32'h10);
    // start completes with no load
    nl <= 1'b1;
    sb <= 1'b1;
    st(1);
    sb <= 1'b0;
    st(2);
    sd <= 1'b1;
    st(3);
    `CHK(code, `SSI_CODE_PB)
    sd <= 1'b0;
    nl <= 1'b0;
    clr(32'h10);
    // mode key twice during start, then a proper start to running
    sb <= 1'b1;
    st(1);
    sb <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      press <= 1'b1;
      st(1);
      press <= 1'b0;
      st(6);
      `CHK(lamps, k ? 4'h0 : 4'h1)
      `CHK(code, k ? `SSI_CODE_STATE : `SSI_CODE_CURRENT)
    end
    st(120);
    byp <= 1'b1;
    sd <= 1'b1;
    st(3);
    `CHK(lamps, 4'h8)
    stp <= 1'b1;
    st(1);
    stp <= 1'b0;
    byp <= 1'b0;
    sd <= 1'b0;
    st(3);
    `CHK(lamps, 4'h0)
    // delay interval, then external control source
    sdb <= 1'b1;
    st(1);
    sdb <= 1'b0;
    st(3);
    `CHK(lamps, 4'h4)
    sde <= 1'b1;
    st(1);
    sde <= 1'b0;
    st(3);
    `CHK(lamps, 4'h0)
    ext <= 1'b1;
    st(3);
    `CHK(lamps, 4'h2)
    wb(1'b0, `SSI_REG_STATUS, 32'h0);
    `CHK(q, 32'h25)
    ext <= 1'b0;
    st(3);
    `CHK(lamps, 4'h0)
    tally_and_finish();
  end
endmodule
bind ssi_top ssi_top_chk #(.BYPASS_MIN_CYCLES(BYPASS_MIN_CYCLES), .CNT_W(CNT_W)) u_chk (.clk(clk),
  .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .prot(prot),
  .stop_cmd(stop_cmd), .display_code(display_code), .lamps(lamps));
